// File: logic/sram_port_pkg.sv
package sram_port_pkg;

  // Burst shape
  localparam int BURST_LEN = 4;
  localparam int BEAT_INDEX_WIDTH = 2;
  localparam int BEAT_COUNT_WIDTH = 3;

  // Write data buffer
  localparam int WRITE_FIFO_DEPTH = 8;

  // Beat counters
  localparam logic [2:0] BEATS_NONE = 3'h0;
  localparam logic [2:0] BEATS_FULL = 3'h4;
  localparam logic [2:0] BEATS_AFTER_FIRST = 3'h3;
  localparam logic [1:0] INDEX_FIRST = 2'h0;
  localparam logic [1:0] INDEX_SECOND = 2'h1;

  // Values after reset
  localparam logic Q_OE_RESET = 1'b0;
  localparam logic PEND_RESET = 1'b0;

  // Positions of the synchronised pins in the sampled vector
  localparam int PIN_K = 0;
  localparam int PIN_K_N = 1;
  localparam int PIN_C = 2;
  localparam int PIN_C_N = 3;
  localparam int PIN_WRITE_SEL_N = 4;
  localparam int PIN_READ_SEL_N = 5;
  localparam int PIN_SINGLE_CLOCK = 6;
  localparam int PIN_ADDR = 7;

  // Each port either waits for a request or ignores the strobe for one cycle
  typedef enum logic {port_idle, port_hold} port_state_t;

endpackage : sram_port_pkg

// File: logic/stream_if.sv
`timescale 1ns/100ps

interface stream_if #(
  parameter int WIDTH = 8
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface : stream_if

// File: logic/pin_sync.sv
`timescale 1ns/100ps

module pin_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Pins from outside the clock domain
  input wire logic [WIDTH-1:0] pin_in,
  // Synchronised levels and rising edges
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] last;
  } sync_state_t;

  sync_state_t state;
  sync_state_t next_state;

  // Only the second stage reads the first one
  always_comb begin
    next_state = state;
    next_state.stage1 = pin_in;
    next_state.stage2 = state.stage1;
    next_state.last = state.stage2;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign level = state.stage2;
  assign rise = state.stage2 & ~state.last;

endmodule : pin_sync

// File: logic/stream_fifo.sv
`timescale 1ns/100ps

module stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Filling side
  stream_if.sink fill,
  // Draining side
  stream_if.source drain
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0] count;
  } fifo_state_t;

  fifo_state_t state;
  fifo_state_t next_state;

  function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] ptr);
    if (ptr == PTR_W'(DEPTH - 1)) begin
      return '0;
    end
    return ptr + PTR_W'(1);
  endfunction : ptr_step

  logic push;
  logic pop;

  always_comb begin
    next_state = state;
    push = fill.valid && fill.ready;
    pop = drain.valid && drain.ready;
    if (push) begin
      next_state.mem[state.wr_ptr] = fill.data;
      next_state.wr_ptr = ptr_step(state.wr_ptr);
    end
    if (pop) begin
      next_state.rd_ptr = ptr_step(state.rd_ptr);
    end
    if (push && !pop) begin
      next_state.count = state.count + (PTR_W + 1)'(1);
    end else if (pop && !push) begin
      next_state.count = state.count - (PTR_W + 1)'(1);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign fill.ready = (state.count != (PTR_W + 1)'(DEPTH));
  assign drain.valid = (state.count != '0);
  assign drain.data = state.mem[state.rd_ptr];

endmodule : stream_fifo

// File: logic/sram_burst4_port_control.sv
// Overview of operation
// R1: The write-select strobe is active low and is looked at on every rising edge of the input clock.
// R2: A low write-select with no write burst under way starts a new write.
// R3: A high write-select deselects the write port and the write data inputs are then ignored.
// R4: An accepted write runs to its end and the write-select of the next cycle is ignored.
// R5: The read-select strobe is active low and is looked at on every rising edge of the input clock.
// R6: A low read-select with no read burst under way starts a new read.
// R7: Deselecting the read port still lets an already pending read finish.
// R8: Once deselected and drained, the read data outputs float after the next output clock rise.
// R9: Every accepted read delivers four sequential words on the read data port.
// R10: An accepted read runs to its end and the read-select of the next cycle is ignored.
// R11: Read data is timed by the positive output clock together with its complement.
// R12: The controller may skew the output clock pair to line up data from several devices.
// R13: The shared address is taken on the input clock rise, reads and writes alternating; the code lets a read and a write both take it on one k rise.
// R14: Read data leaves on rises of both output clocks, or of the input clock pair in single mode.
// R15: All synchronous inputs are captured, and accesses start, on the input clock rise; the code also takes write data on k_n rises.
// R16: An accepted write takes four words at double data rate over the next two input clocks.
`timescale 1ns/100ps

module sram_burst4_port_control #(
  parameter int ADDR_WIDTH = 6,
  parameter int DATA_WIDTH = 18
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Input clock pair and output clock pair
  input wire logic k,
  input wire logic k_n,
  input wire logic c,
  input wire logic c_n,
  input wire logic single_clock_mode,
  // Strobes and address
  input wire logic write_sel_n,
  input wire logic read_sel_n,
  input wire logic [ADDR_WIDTH-1:0] shared_address_bus,
  // Write data port
  input wire logic [DATA_WIDTH-1:0] write_data,
  // Read data port
  output logic [DATA_WIDTH-1:0] read_data,
  output logic read_data_oe,
  // Status
  output logic write_buffer_ready
);

  ////////////////////////////////////////////////////////////////////////////////
  // Sizes

  localparam int IW = sram_port_pkg::BEAT_INDEX_WIDTH;
  localparam int CW = sram_port_pkg::BEAT_COUNT_WIDTH;
  localparam int BL = sram_port_pkg::BURST_LEN;
  localparam int MEM_WORDS = (2 ** ADDR_WIDTH) * BL;
  localparam int MEM_AW = ADDR_WIDTH + IW;
  localparam int ENTRY_W = MEM_AW + DATA_WIDTH;
  localparam int PIN_W = sram_port_pkg::PIN_ADDR + ADDR_WIDTH + DATA_WIDTH;
  localparam int PIN_DATA = sram_port_pkg::PIN_ADDR + ADDR_WIDTH;

  ////////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [MEM_WORDS-1:0][DATA_WIDTH-1:0] mem;
    sram_port_pkg::port_state_t write_state;
    sram_port_pkg::port_state_t read_state;
    logic [CW-1:0] wr_beats;
    logic [ADDR_WIDTH-1:0] wr_addr;
    logic [IW-1:0] wr_index;
    logic pend_valid;
    logic [BL-1:0][DATA_WIDTH-1:0] pend_buf;
    logic [BL-1:0][DATA_WIDTH-1:0] out_buf;
    logic [CW-1:0] out_left;
    logic [IW-1:0] out_index;
    logic [DATA_WIDTH-1:0] q;
    logic q_oe;
    logic [2:0] settle;
  } port_ctrl_state_t;

  port_ctrl_state_t state;
  port_ctrl_state_t next_state;

  // Word address inside the array for one beat of a burst
  function automatic logic [MEM_AW-1:0] mem_word(
    input logic [ADDR_WIDTH-1:0] addr,
    input logic [IW-1:0] beat
  );
    return {addr, beat};
  endfunction : mem_word

  ////////////////////////////////////////////////////////////////////////////////
  // Pin sampling

  logic [PIN_W-1:0] pins;
  logic [PIN_W-1:0] pin_level;
  logic [PIN_W-1:0] pin_rise;

  assign pins = {
    write_data,
    shared_address_bus,
    single_clock_mode,
    read_sel_n,
    write_sel_n,
    c_n,
    c,
    k_n,
    k
  };

  pin_sync #(
    .WIDTH(PIN_W)
  ) u_pin_sync (
    .clk(clk),
    .reset(reset),
    .pin_in(pins),
    .level(pin_level),
    .rise(pin_rise)
  );

  logic k_rise;
  logic k_n_rise;
  logic c_rise;
  logic c_n_rise;
  logic single_mode;
  logic write_req;
  logic read_req;
  logic [ADDR_WIDTH-1:0] addr_in;
  logic [DATA_WIDTH-1:0] data_in;

  ////////////////////////////////////////////////////////////////////////////////
  // Edge qualification

  // The edge flop holds zero after reset, so a pin already high would pass for
  // a fresh rise; edges count only once all three stages hold real pin samples
  logic edges_ok;

  assign edges_ok = state.settle[2];
  assign k_rise = edges_ok && pin_rise[sram_port_pkg::PIN_K];
  assign k_n_rise = edges_ok && pin_rise[sram_port_pkg::PIN_K_N];
  assign c_rise = edges_ok && pin_rise[sram_port_pkg::PIN_C];
  assign c_n_rise = edges_ok && pin_rise[sram_port_pkg::PIN_C_N];
  assign single_mode = pin_level[sram_port_pkg::PIN_SINGLE_CLOCK];
  assign write_req = !pin_level[sram_port_pkg::PIN_WRITE_SEL_N]; // see R1
  assign read_req = !pin_level[sram_port_pkg::PIN_READ_SEL_N]; // see R5
  assign addr_in = pin_level[sram_port_pkg::PIN_ADDR +: ADDR_WIDTH];
  assign data_in = pin_level[PIN_DATA +: DATA_WIDTH];

  ////////////////////////////////////////////////////////////////////////////////
  // Write data buffer

  stream_if #(.WIDTH(ENTRY_W)) wr_fill ();
  stream_if #(.WIDTH(ENTRY_W)) wr_drain ();

  stream_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(sram_port_pkg::WRITE_FIFO_DEPTH)
  ) u_write_fifo (
    .clk(clk),
    .reset(reset),
    .fill(wr_fill),
    .drain(wr_drain)
  );

  logic push_valid;
  logic [ENTRY_W-1:0] push_data;
  logic drain_ready;
  logic read_accept;
  logic in_edge;
  logic out_edge;
  logic close_edge;

  assign wr_fill.valid = push_valid;
  assign wr_fill.data = push_data;
  assign wr_drain.ready = drain_ready;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_state = state;
    // Fills with ones one stage per cycle after reset
    next_state.settle = {state.settle[1:0], 1'b1};
    push_valid = 1'b0;
    push_data = '0;
    read_accept = 1'b0;
    in_edge = k_rise || k_n_rise;
    out_edge = single_mode ? in_edge : (c_rise || c_n_rise); // see R11, R14
    close_edge = single_mode ? k_rise : c_rise;

    // Write beats at both input clock rises; the last beat may meet a new request
    if (in_edge && state.wr_beats != sram_port_pkg::BEATS_NONE) begin // see R16
      push_valid = 1'b1;
      push_data = {mem_word(state.wr_addr, state.wr_index), data_in};
      next_state.wr_index = state.wr_index + IW'(1);
      next_state.wr_beats = state.wr_beats - CW'(1);
    end

    // Write strobe; a high level simply starts nothing, and no data is taken unless a write burst is under way
    if (k_rise) begin // see R15
      case (state.write_state)
        sram_port_pkg::port_idle: begin
          if (write_req) begin // see R2, R3, R13
            next_state.write_state = sram_port_pkg::port_hold;
            next_state.wr_beats = sram_port_pkg::BEATS_FULL;
            next_state.wr_addr = addr_in;
            next_state.wr_index = sram_port_pkg::INDEX_FIRST;
          end
        end
        sram_port_pkg::port_hold: begin
          next_state.write_state = sram_port_pkg::port_idle; // see R4
        end
        default: begin
          next_state.write_state = sram_port_pkg::port_idle;
        end
      endcase
    end

    // Output side: drive the current burst, then a pending one, then float
    if (out_edge) begin
      if (state.out_left != sram_port_pkg::BEATS_NONE) begin // see R9
        next_state.q = state.out_buf[state.out_index];
        next_state.q_oe = 1'b1;
        next_state.out_index = state.out_index + IW'(1);
        next_state.out_left = state.out_left - CW'(1);
      end else if (state.pend_valid) begin // see R7
        next_state.out_buf = state.pend_buf;
        next_state.q = state.pend_buf[sram_port_pkg::INDEX_FIRST];
        next_state.q_oe = 1'b1;
        next_state.out_index = sram_port_pkg::INDEX_SECOND;
        next_state.out_left = sram_port_pkg::BEATS_AFTER_FIRST;
        next_state.pend_valid = 1'b0;
      end else if (close_edge) begin
        next_state.q_oe = 1'b0; // see R8
      end
    end

    // Read strobe; the burst is fetched into the pending slot at once
    if (k_rise) begin // see R15
      case (state.read_state)
        sram_port_pkg::port_idle: begin
          if (read_req) begin // see R6, R13
            read_accept = 1'b1;
            next_state.read_state = sram_port_pkg::port_hold;
            next_state.pend_valid = 1'b1;
            for (int i = 0; i < BL; i++) begin
              next_state.pend_buf[i] = state.mem[mem_word(addr_in, IW'(i))];
            end
          end
        end
        sram_port_pkg::port_hold: begin
          next_state.read_state = sram_port_pkg::port_idle; // see R10
        end
        default: begin
          next_state.read_state = sram_port_pkg::port_idle;
        end
      endcase
    end

    // Buffered write words reach the array except while a read is fetched
    drain_ready = !read_accept;
    if (wr_drain.valid && drain_ready) begin
      next_state.mem[wr_drain.data[DATA_WIDTH +: MEM_AW]] = wr_drain.data[DATA_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign read_data = state.q;
  assign read_data_oe = state.q_oe;
  assign write_buffer_ready = wr_fill.ready;

endmodule : sram_burst4_port_control

// File: dv/ctrl_clock_model.sv
`timescale 1ns/100ps

module ctrl_clock_model #(
  parameter int HALF = 40,
  parameter int SKEW = 13
) (
  // Input clock pair
  output logic k,
  output logic k_n,
  // Output clock pair
  output logic c,
  output logic c_n
);
  // Requests are timed by k; the output pair trails it like board flight time
  initial begin
    k = 1'b0;
    k_n = 1'b1;
    c = 1'b0;
    c_n = 1'b1;
    #3;
    forever begin
      #(HALF - SKEW);
      k = ~k;
      k_n = ~k_n;
      #SKEW;
      c = ~c;
      c_n = ~c_n;
    end
  end
endmodule : ctrl_clock_model

// File: dv/sram_burst4_port_control_chk.sv
`timescale 1ns/100ps

module sram_burst4_port_control_chk #(
  parameter int ADDR_WIDTH = 6,
  parameter int DATA_WIDTH = 18
) (
  // Clocks and mode
  input wire logic clk,
  input wire logic reset,
  input wire logic k,
  input wire logic k_n,
  input wire logic c,
  input wire logic c_n,
  input wire logic single_clock_mode,
  // Strobes and data
  input wire logic write_sel_n,
  input wire logic read_sel_n,
  input wire logic [ADDR_WIDTH-1:0] shared_address_bus,
  input wire logic [DATA_WIDTH-1:0] write_data,
  input wire logic [DATA_WIDTH-1:0] read_data,
  input wire logic read_data_oe,
  input wire logic write_buffer_ready
);
  logic [5:0] s1, s2, s3, rise;
  logic hold_r, hold_w, oedge, odrop, acc_r, acc_w;
  logic [5:0] rd_since, wr_since;
  logic [3:0] beats;
  assign rise = s2 & ~s3;
  assign oedge = single_clock_mode ? (rise[5] | rise[4]) : (rise[3] | rise[2]);
  assign odrop = single_clock_mode ? rise[5] : rise[3];
  assign acc_r = rise[5] & ~s2[1] & ~hold_r;
  assign acc_w = rise[5] & ~s2[0] & ~hold_w;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1 <= 6'h03;
      s2 <= 6'h03;
      s3 <= 6'h03;
      hold_r <= 1'b0;
      hold_w <= 1'b0;
      rd_since <= 6'h3F;
      wr_since <= 6'h3F;
      beats <= 4'h0;
    end else begin
      s1 <= {k, k_n, c, c_n, read_sel_n, write_sel_n};
      s2 <= s1;
      s3 <= s2;
      hold_r <= acc_r | (hold_r & ~rise[5]);
      hold_w <= acc_w | (hold_w & ~rise[5]);
      rd_since <= acc_r ? 6'h00 : rd_since + {5'h00, rd_since != 6'h3F};
      wr_since <= acc_w ? 6'h00 : wr_since + {5'h00, wr_since != 6'h3F};
      beats <= !read_data_oe ? 4'h0 : beats + {3'h0, oedge && beats != 4'hF};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_read_taken;
    acc_r;
  endsequence
  chk_data_on_edge: assert property (read_data_oe && $changed(read_data) |->
    oedge || $past(oedge) || $past(oedge, 2)) else $error("read data moved off an edge");
  chk_oe_rise_edge: assert property ($rose(read_data_oe) |->
    oedge || $past(oedge) || $past(oedge, 2)) else $error("output enable rose off an edge");
  chk_oe_drop_edge: assert property ($fell(read_data_oe) |->
    odrop || $past(odrop) || $past(odrop, 2)) else $error("output enable fell off a rise");
  chk_read_start: assert property (s_read_taken |-> ##[1:16] read_data_oe)
    else $error("accepted read gave no data");
  chk_burst_len: assert property ($fell(read_data_oe) |-> beats >= 4'h3)
    else $error("read burst cut short");
  chk_oe_cause: assert property ($rose(read_data_oe) |-> rd_since <= 6'h10)
    else $error("output enable without a read");
  chk_oe_idle: assert property (rd_since == 6'h30 |-> !read_data_oe)
    else $error("read port still driving");
  chk_wbuf_drain: assert property (wr_since == 6'h30 |-> write_buffer_ready)
    else $error("write buffer never drained");
endmodule : sram_burst4_port_control_chk

bind sram_burst4_port_control sram_burst4_port_control_chk #(
  .ADDR_WIDTH(ADDR_WIDTH), .DATA_WIDTH(DATA_WIDTH)
) u_chk (
  .clk(clk), .reset(reset), .k(k), .k_n(k_n), .c(c), .c_n(c_n),
  .single_clock_mode(single_clock_mode), .write_sel_n(write_sel_n),
  .read_sel_n(read_sel_n), .shared_address_bus(shared_address_bus),
  .write_data(write_data), .read_data(read_data), .read_data_oe(read_data_oe),
  .write_buffer_ready(write_buffer_ready)
);

// File: dv/tb_sram_burst4_port_control.sv
`timescale 1ns/100ps

module tb_sram_burst4_port_control;
  typedef struct packed {logic [5:0] a; logic [17:0] d;} row_t;
  logic clk, reset, k, k_n, c, c_n, single_clock_mode, write_sel_n, read_sel_n;
  logic read_data_oe, write_buffer_ready;
  logic [5:0] shared_address_bus;
  logic [17:0] write_data, read_data, last;
  logic [17:0] got[$];
  int error_cnt, n_checks;
  row_t rows [3] = '{'{6'h00, 18'h00100}, '{6'h3F, 18'h3FF00}, '{6'h15, 18'h2A5A0}};
  row_t b0 = '{6'h0A, 18'h12340};
  row_t b1 = '{6'h0B, 18'h05670};

  ctrl_clock_model u_clk (.k(k), .k_n(k_n), .c(c), .c_n(c_n));
  sram_burst4_port_control u_dut (
    .clk(clk), .reset(reset), .k(k), .k_n(k_n), .c(c), .c_n(c_n),
    .single_clock_mode(single_clock_mode), .write_sel_n(write_sel_n),
    .read_sel_n(read_sel_n), .shared_address_bus(shared_address_bus),
    .write_data(write_data), .read_data(read_data), .read_data_oe(read_data_oe),
    .write_buffer_ready(write_buffer_ready)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Bounds the whole run
  initial begin
    repeat (20000) @(negedge clk);
    error_cnt++;
    close_out();
  end

  // Collects each new word while the read port drives
  initial begin
    last = 18'h00000;
    forever begin
      @(negedge clk);
      if (read_data_oe === 1'b1 && read_data !== last) got.push_back(read_data);
      last = read_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task close_out;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  task chk_word(input logic [17:0] g, input logic [17:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_word

  task chk_bit(input logic g, input logic e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_bit

  task slot;
    @(negedge k);
    repeat (2) @(negedge clk);
  endtask : slot

  // Strobe and address go out in the slot before a k rise
  task wr(input row_t r, input bit more);
    write_sel_n = 1'b0;
    shared_address_bus = r.a;
    @(posedge k);
    repeat (2) @(negedge clk);
    write_data = r.d;
    write_sel_n = !more;
    for (int i = 1; i < 4; i++) begin
      @(k);
      repeat (2) @(negedge clk);
      write_data = r.d + 18'(i);
    end
    if (!more) begin
      @(posedge k);
      repeat (2) @(negedge clk);
      write_data = 18'h3FFFF;
    end
  endtask : wr

  task rd(input row_t r, input bit more);
    read_sel_n = 1'b0;
    shared_address_bus = r.a;
    @(posedge k);
    if (more) @(posedge k);
    repeat (2) @(negedge clk);
    read_sel_n = !more;
  endtask : rd

  task drain(input int n);
    for (int i = 0; i < 400 && got.size() < n; i++) @(negedge clk);
    for (int i = 0; i < 60 && read_data_oe !== 1'b0; i++) @(negedge clk);
    if (got.size() < n) begin
      error_cnt++;
      close_out();
    end
    chk_bit(read_data_oe, 1'b0);
    chk_word(18'(got.size()), 18'(n));
  endtask : drain

  task expect4(input row_t r, input int off);
    for (int i = 0; i < 4; i++) chk_word(got[off + i], r.d + 18'(i));
  endtask : expect4

  task read_back(input row_t r);
    repeat (16) @(negedge clk);
    slot();
    got.delete();
    rd(r, 1'b0);
    drain(4);
    expect4(r, 0);
  endtask : read_back

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    single_clock_mode = 1'b0;
    write_sel_n = 1'b1;
    read_sel_n = 1'b1;
    shared_address_bus = 6'h00;
    write_data = 18'h00000;
    error_cnt = 0;
    n_checks = 0;
    repeat (6) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    chk_bit(read_data_oe, 1'b0);
    chk_bit(write_buffer_ready, 1'b1);
    foreach (rows[i]) begin
      slot();
      wr(rows[i], 1'b0);
      read_back(rows[i]);
    end
    // Strobes held low across back-to-back bursts
    slot();
    wr(b0, 1'b1);
    wr(b1, 1'b0);
    repeat (16) @(negedge clk);
    slot();
    got.delete();
    rd(b0, 1'b1);
    rd(b1, 1'b0);
    drain(8);
    expect4(b0, 0);
    expect4(b1, 4);
    single_clock_mode = 1'b1;
    read_back(rows[2]);
    single_clock_mode = 1'b0;
    // Reset in mid-burst: the port floats at once and restarts clean
    slot();
    rd(rows[2], 1'b0);
    for (int i = 0; i < 40 && read_data_oe !== 1'b1; i++) @(negedge clk);
    reset = 1'b1;
    repeat (2) @(negedge clk);
    chk_bit(read_data_oe, 1'b0);
    reset = 1'b0;
    @(negedge clk);
    chk_bit(read_data_oe, 1'b0);
    chk_bit(write_buffer_ready, 1'b1);
    slot();
    wr(rows[1], 1'b0);
    read_back(rows[1]);
    close_out();
  end
endmodule : tb_sram_burst4_port_control
